// ==== common/integrity_pkg.sv ====
// Constants for the reset and supply integrity block
package integrity_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] MCC_IDX = 8'h3a;
  localparam logic [7:0] TRIM_IDX = 8'h3b;
  localparam logic [7:0] STATUS_IDX = 8'h3c;
  localparam logic [7:0] THRESH_IDX = 8'h3d;
  localparam logic [7:0] WDG_IDX = 8'h40;
  localparam int ADDR_W = 10;
  // Field positions
  localparam int MCC_SLOW_BIT = 0;
  localparam int MCC_CLKOUT_BIT = 1;
  localparam int ST_IRQEN_BIT = 0;
  localparam int ST_WARN_BIT = 1;
  localparam int ST_LOWRF_BIT = 2;
  localparam int ST_WDGRF_BIT = 4;
  localparam int ST_TRIMLO_LSB = 5;
  // Reset values
  localparam logic [7:0] MCC_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'hff;
  localparam logic [1:0] TRIMLO_RESET = 2'h3;
  localparam logic [1:0] THRESH_RESET = 2'h0;
  // Timing
  localparam int SLOW_DIV = 32;
  localparam int DELAY_SHORT = 256;
  localparam int DELAY_LONG = 4096;
  localparam int FETCH_CYCLES = 2;
  localparam int WDG_PULSE_NS = 20000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WDG_PULSE_CYC = (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== core/reset_and_supply_integrity.sv ====
// Reset merge, supply integrity status and clock control registers
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module reset_and_supply_integrity
  import integrity_pkg::*;
#(
  parameter int DELAY_LONG_CYC = DELAY_LONG
)
(
  input wire logic core_clk,
  input wire logic rstn,
  // Reset pin as three signals
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Analog, option, watchdog and core inputs
  input wire logic supply_low_raw,
  input wire logic warning_raw,
  input wire logic opt_low_detect_en,
  input wire logic [1:0] opt_low_threshold,
  input wire logic opt_short_delay,
  input wire logic watchdog_underflow,
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic irq_ack,
  // Outputs to analog and core
  output logic [1:0] low_threshold_sel,
  output logic low_detect_enable,
  output logic [1:0] warning_threshold_select,
  output logic [9:0] osc_trim,
  output logic clock_out_en,
  output logic slow_clk_en,
  output logic core_reset_n,
  output logic cpu_run,
  output logic warn_irq,
  output logic wake_req,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_FETCH, ST_RUN} seq_e;

  seq_e seq_q, seq_d;

  // ********************************************
  // Functions
  // ********************************************

  // Map a byte address onto a register index
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:2];
  endfunction

  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == MCC_IDX) || (i == TRIM_IDX) || (i == STATUS_IDX) ||
             (i == THRESH_IDX) || (i == WDG_IDX);
  endfunction

  // ********************************************
  // Synchronisers
  // ********************************************

  logic [1:0] pin_s_q, low_s_q, warn_s_q, wdg_s_q;
  logic [1:0] rel_s_q;
  logic warn_prev_q;

  // Two flops on every asynchronous input
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s_q <= 2'h3;
      low_s_q <= 2'h0;
      warn_s_q <= 2'h0;
      wdg_s_q <= 2'h0;
      warn_prev_q <= 1'b0;
    end
    else
    begin
      pin_s_q <= {pin_s_q[0], reset_pin_in};
      low_s_q <= {low_s_q[0], supply_low_raw};
      warn_s_q <= {warn_s_q[0], warning_raw};
      wdg_s_q <= {wdg_s_q[0], watchdog_underflow};
      warn_prev_q <= warn_s_q[1];
    end
  end

  // ********************************************
  // Reset sources and pin drive
  // ********************************************

  logic supply_low, wdg_rise, wdg_prev_q;
  logic [15:0] pulse_cnt_q, pulse_cnt_d;
  logic pin_low;
  logic async_rst_n;
  logic pin_drive_q;

  assign supply_low = low_s_q[1] & opt_low_detect_en;
  assign low_detect_enable = opt_low_detect_en;
  assign low_threshold_sel = opt_low_threshold;
  assign wdg_rise = wdg_s_q[1] & ~wdg_prev_q;

  always_comb
  begin
    pulse_cnt_d = pulse_cnt_q;
    if (wdg_rise)
      pulse_cnt_d = 16'(WDG_PULSE_CYC);
    else if (pulse_cnt_q != 16'h0)
      pulse_cnt_d = pulse_cnt_q - 16'h1;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pulse_cnt_q <= 16'h0;
      wdg_prev_q <= 1'b0;
      pin_drive_q <= 1'b1;
    end
    else
    begin
      pulse_cnt_q <= pulse_cnt_d;
      wdg_prev_q <= wdg_s_q[1];
      pin_drive_q <= reset_pin_oe;
    end
  end

  // open drain: output always low, enable pulls
  assign pin_low = supply_low | (pulse_cnt_q != 16'h0) | (seq_q != ST_RUN);
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = pin_low;

  // external pin resets without a clock; supply-low holds statically.
  // Own pull masked, plus one cycle after release, or the pin would relatch us
  assign async_rst_n = rstn & (reset_pin_in | reset_pin_oe | pin_drive_q) &
                       ~(supply_low_raw & opt_low_detect_en);

  always_ff @(posedge core_clk or negedge async_rst_n)
  begin
    if (!async_rst_n)
      rel_s_q <= 2'h0;
    else
      rel_s_q <= {rel_s_q[0], 1'b1};
  end

  // ********************************************
  // Reset sequence
  // ********************************************

  logic [12:0] dly_q, dly_d;
  logic [12:0] dly_len;
  logic hold_req;

  // Watchdog pulse also reruns the sequence
  assign hold_req = ~rel_s_q[1] | (pulse_cnt_q != 16'h0) | supply_low;
  // delay length by clock source option
  assign dly_len = opt_short_delay ? 13'(DELAY_SHORT - 1) : 13'(DELAY_LONG_CYC - 1);

  always_comb
  begin
    seq_d = seq_q;
    dly_d = dly_q;
    if (hold_req)
    begin
      seq_d = ST_HOLD;
      dly_d = 13'h0;
    end
    else
    begin
      unique case (seq_q)
        ST_HOLD:
        begin
          seq_d = ST_DELAY;
          dly_d = dly_len;
        end
        ST_DELAY:
        begin
          if (dly_q == 13'h0)
          begin
            seq_d = ST_FETCH;
            dly_d = 13'(FETCH_CYCLES - 1);
          end
          else
            dly_d = dly_q - 13'h1;
        end
        ST_FETCH:
        begin
          if (dly_q == 13'h0)
            seq_d = ST_RUN;
          else
            dly_d = dly_q - 13'h1;
        end
        ST_RUN:
          seq_d = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seq_q <= ST_HOLD;
      dly_q <= 13'h0;
    end
    else
    begin
      seq_q <= seq_d;
      dly_q <= dly_d;
    end
  end

  // core drops at once on pin, supply-low or power-on reset, even with the clock stopped
  assign core_reset_n = rel_s_q[1] && ((seq_q == ST_FETCH) || (seq_q == ST_RUN));
  assign cpu_run = rel_s_q[1] && (seq_q == ST_RUN);

  // ********************************************
  // Registers
  // ********************************************

  logic [7:0] mcc_q, mcc_d, trim_q, trim_d;
  logic [1:0] trimlo_q, trimlo_d, thr_q, thr_d;
  logic irqen_q, irqen_d, wdgrf_q, wdgrf_d, lowrf_q, lowrf_d;
  logic warnf_q, warnf_d, pend_q, pend_d;
  logic wr_go, rd_go;
  logic [7:0] wr_idx, rd_idx;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;

  assign wr_go = aw_have_q & w_have_q & ~s_bvalid;
  assign wr_idx = reg_index(awaddr_q);
  assign rd_go = s_arvalid & s_arready;
  assign rd_idx = reg_index(s_araddr);

  // Register state; a hardware set beats a software clear
  always_comb
  begin
    mcc_d = mcc_q;
    trim_d = trim_q;
    trimlo_d = trimlo_q;
    thr_d = thr_q;
    irqen_d = irqen_q;
    wdgrf_d = wdgrf_q;
    lowrf_d = lowrf_q;
    warnf_d = warnf_q;
    pend_d = pend_q;
    if (wr_go && wstrb_q[0])
    begin
      unique case (wr_idx)
        // reserved bits stored as zero regardless
        MCC_IDX: mcc_d = {6'h0, wdata_q[1:0]};
        TRIM_IDX: trim_d = wdata_q[7:0];
        STATUS_IDX:
        begin
          trimlo_d = wdata_q[ST_TRIMLO_LSB +: 2];
          irqen_d = wdata_q[ST_IRQEN_BIT];
          if (!wdata_q[ST_WDGRF_BIT])
            wdgrf_d = 1'b0;
        end
        THRESH_IDX: thr_d = wdata_q[1:0];
        default: ;
      endcase
    end
    // Low-reset flag clears on status read
    if (rd_go && rd_idx == STATUS_IDX)
      lowrf_d = 1'b0;
    if (wdg_rise)
      wdgrf_d = 1'b1;
    if (supply_low)
    begin
      wdgrf_d = 1'b0;
      lowrf_d = 1'b1;
    end
    if (!halt_mode)
      warnf_d = warn_s_q[1];
    if (warn_s_q[1] != warn_prev_q && irqen_q)
      pend_d = 1'b1;
    else if (irq_ack)
      pend_d = 1'b0;
  end

  // Register file flops; reset-cause flags reset only on power-on reset input
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mcc_q <= MCC_RESET;
      trim_q <= TRIM_RESET;
      trimlo_q <= TRIMLO_RESET;
      thr_q <= THRESH_RESET;
      irqen_q <= 1'b0;
      wdgrf_q <= 1'b0;
      lowrf_q <= 1'b0;
      warnf_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else if (!core_reset_n && !wdg_rise && !supply_low)
    begin
      // Internal reset restores control bits, keeps reset-cause flags
      mcc_q <= MCC_RESET;
      trim_q <= TRIM_RESET;
      trimlo_q <= TRIMLO_RESET;
      thr_q <= THRESH_RESET;
      irqen_q <= 1'b0;
      pend_q <= 1'b0;
      warnf_q <= warnf_d;
    end
    else
    begin
      mcc_q <= mcc_d;
      trim_q <= trim_d;
      trimlo_q <= trimlo_d;
      thr_q <= thr_d;
      irqen_q <= irqen_d;
      wdgrf_q <= wdgrf_d;
      lowrf_q <= lowrf_d;
      warnf_q <= warnf_d;
      pend_q <= pend_d;
    end
  end

  assign clock_out_en = mcc_q[MCC_CLKOUT_BIT];
  assign warning_threshold_select = thr_q;
  // trim word, higher code means slower
  assign osc_trim = {trim_q, trimlo_q};
  assign warn_irq = pend_q & irqen_q & ~cpu_irq_mask;
  assign wake_req = warn_irq & wait_mode & ~halt_mode;

  // ********************************************
  // Slow clock enable divider
  // ********************************************

  logic [4:0] div_q, div_d;

  // one-cycle enable every 32 cycles in slow mode
  always_comb
  begin
    div_d = (div_q == 5'(SLOW_DIV - 1)) ? 5'h0 : div_q + 5'h1;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      div_q <= 5'h0;
    else
      div_q <= div_d;
  end

  assign slow_clk_en = mcc_q[MCC_SLOW_BIT] ? (div_q == 5'h0) : 1'b1;

  // ********************************************
  // AXI4-Lite slave
  // ********************************************

  logic bvalid_d, bvalid_q, rvalid_d, rvalid_q;
  logic [1:0] bresp_d, bresp_q, rresp_d, rresp_q;
  logic [31:0] rdata_d, rdata_q;

  assign s_awready = ~aw_have_q;
  assign s_wready = ~w_have_q;
  assign s_arready = ~rvalid_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_rvalid = rvalid_q;
  assign s_rresp = rresp_q;
  assign s_rdata = rdata_q;

  // Bus channel state
  always_comb
  begin
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_awvalid && s_awready)
    begin
      awaddr_d = s_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_wvalid && s_wready)
    begin
      wdata_d = s_wdata;
      wstrb_d = s_wstrb;
      w_have_d = 1'b1;
    end
    if (wr_go)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && s_bready)
      bvalid_d = 1'b0;
    if (rd_go)
    begin
      rvalid_d = 1'b1;
      rresp_d = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      unique case (rd_idx)
        MCC_IDX: rdata_d = {24'h0, mcc_q};
        TRIM_IDX: rdata_d = {24'h0, trim_q};
        STATUS_IDX: rdata_d = {25'h0, trimlo_q, wdgrf_q, 1'b0, lowrf_q, warnf_q, irqen_q};
        THRESH_IDX: rdata_d = {30'h0, thr_q};
        WDG_IDX: rdata_d = {24'h0, 5'h0, seq_q == ST_RUN, pin_s_q[1], supply_low};
        default: rdata_d = 32'h0;
      endcase
    end
    else if (rvalid_q && s_rready)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end
    else
    begin
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

endmodule

// ==== testbench/integrity_properties.sv ====
// Port-level checker for the reset and supply integrity block
`timescale 1ns/1ps
module integrity_properties
  import integrity_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic supply_low_raw,
  input wire logic opt_low_detect_en,
  input wire logic [1:0] opt_low_threshold,
  input wire logic watchdog_underflow,
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic [1:0] low_threshold_sel,
  input wire logic low_detect_enable,
  input wire logic slow_clk_en,
  input wire logic core_reset_n,
  input wire logic cpu_run,
  input wire logic warn_irq,
  input wire logic wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ********
  // Helpers
  // ********
  // Length of the current pin-low stretch; saturates so it never wraps
  logic [8:0] oe_run_q;
  logic [8:0] oe_run_d;
  logic wdg_seen_q;
  logic wdg_seen_d;
  always_comb
  begin
    oe_run_d = 9'h000;
    if (reset_pin_oe)
      oe_run_d = (oe_run_q == 9'h1ff) ? oe_run_q : oe_run_q + 9'h001;
    wdg_seen_d = watchdog_underflow | (wdg_seen_q & reset_pin_oe);
  end
  // Registered helper state
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oe_run_q <= 9'h000;
      wdg_seen_q <= 1'b0;
    end
    else
    begin
      oe_run_q <= oe_run_d;
      wdg_seen_q <= wdg_seen_d;
    end
  end
  // ********
  // Checks
  // ********
  property p_pin_drive;
    !reset_pin_out;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin driven high");
  property p_low_pin;
    (opt_low_detect_en && supply_low_raw)[*3] |-> reset_pin_oe;
  endproperty
  a_low_pin: assert property (p_low_pin) else $error("pin free in low supply");
  property p_low_core;
    (opt_low_detect_en && supply_low_raw)[*4] |-> !core_reset_n && !cpu_run;
  endproperty
  a_low_core: assert property (p_low_core) else $error("core runs in low supply");
  property p_wdg_len;
    $fell(reset_pin_oe) && wdg_seen_q |-> oe_run_q >= 9'(WDG_PULSE_CYC);
  endproperty
  a_wdg_len: assert property (p_wdg_len) else $error("watchdog pulse short");
  property p_opts;
    low_detect_enable == opt_low_detect_en && low_threshold_sel == opt_low_threshold;
  endproperty
  a_opts: assert property (p_opts) else $error("detector option lost");
  property p_irq_gate;
    cpu_irq_mask |-> !warn_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while masked");
  property p_wake;
    warn_irq && wait_mode && !halt_mode |-> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from wait");
  property p_halt;
    halt_mode |-> !wake_req;
  endproperty
  a_halt: assert property (p_halt) else $error("wake from halt");
  // Leading low cycle keeps the switch into slow mode out of the check
  property p_slow;
    !slow_clk_en ##1 slow_clk_en ##1 !slow_clk_en |-> ##31 slow_clk_en;
  endproperty
  a_slow: assert property (p_slow) else $error("slow period wrong");
  property p_fetch;
    $rose(core_reset_n) |-> !cpu_run ##1 !cpu_run ##1 cpu_run;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch length wrong");
endmodule

bind reset_and_supply_integrity integrity_properties u_integrity_properties (.*);

// ==== testbench/far_side.sv ====
// Board-side model: reset pin wire, supply comparators, watchdog line
`timescale 1ns/1ps
module far_side (
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  input wire logic ext_low,
  input wire logic low_cmd,
  input wire logic warn_cmd,
  input wire logic wdg_cmd,
  output logic reset_pin_in,
  output logic supply_low_raw,
  output logic warning_raw,
  output logic watchdog_underflow
);
  assign reset_pin_in = !(ext_low || (reset_pin_oe && !reset_pin_out));
  // Comparators move off the clock grid, so synchronisers see a real async edge
  initial
  begin
    supply_low_raw = 1'b0;
    warning_raw = 1'b0;
  end
  always @(low_cmd)
    supply_low_raw <= #37 low_cmd;
  always @(warn_cmd)
    warning_raw <= #41 warn_cmd;
  assign watchdog_underflow = wdg_cmd;
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the reset and supply integrity block
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb
  import integrity_pkg::*;
;
  localparam int DLY = 16;
  logic core_clk = 1'b0;
  logic clk_on = 1'b1;
  logic rstn, reset_pin_in, reset_pin_out, reset_pin_oe, supply_low_raw, warning_raw;
  logic opt_low_detect_en, opt_short_delay, watchdog_underflow, cpu_irq_mask;
  logic wait_mode, halt_mode, irq_ack, low_detect_enable, clock_out_en, slow_clk_en;
  logic core_reset_n, cpu_run, warn_irq, wake_req, ext_low, low_cmd, warn_cmd, wdg_cmd;
  logic [1:0] opt_low_threshold, low_threshold_sel, warning_threshold_select, r;
  logic [1:0] s_bresp, s_rresp;
  logic [9:0] osc_trim;
  logic [ADDR_W-1:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, q;
  logic [3:0] s_wstrb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int miscompares, comparisons, n;
  // Clock can be parked to model a halted oscillator
  always #50 if (clk_on) core_clk = ~core_clk;
  reset_and_supply_integrity #(.DELAY_LONG_CYC(DLY)) u_reset_and_supply_integrity (.*);
  far_side u_far_side (.*);
  // ********
  // Shared tasks
  // ********
  task automatic results();
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Bounded wait for the core to leave reset
  task automatic wait_run(output int k);
    k = 0;
    while (cpu_run !== 1'b1 && k < 5000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 5000)
    begin
      miscompares++;
      results();
    end
  endtask
  // One bus transfer; address and data offered together, held until taken
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic [1:0] rr);
    int k;
    k = 0;
    @(posedge core_clk);
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= d;
    s_awvalid <= w;
    s_wvalid <= w;
    s_arvalid <= !w;
    s_bready <= w;
    s_rready <= !w;
    do
    begin
      @(posedge core_clk);
      k++;
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
      if (s_arready)
        s_arvalid <= 1'b0;
    end
    while (!(w ? s_bvalid : s_rvalid) && k < 50);
    rq = s_rdata;
    rr = w ? s_bresp : s_rresp;
    s_bready <= 1'b0;
    s_rready <= 1'b0;
    if (k >= 50)
    begin
      miscompares++;
      results();
    end
  endtask
  // ********
  // Scenarios
  // ********
  task automatic s_regs();
    bus(0, 10'h0e8, 0, q, r);
    `CHK(q, 32'h0)
    bus(0, 10'h0ec, 0, q, r);
    `CHK({q, osc_trim}, {32'hff, 10'h3ff})
    bus(0, 10'h0f0, 0, q, r);
    `CHK({q[6:5], q[0]}, 3'b110)
    bus(1, 10'h0e8, 32'h3, q, r);
    bus(0, 10'h0e8, 0, q, r);
    `CHK({q, clock_out_en}, {32'h3, 1'b1})
    cyc(70);
    bus(1, 10'h0ec, 32'h80, q, r);
    bus(1, 10'h0f0, 32'h20, q, r);
    `CHK({r, osc_trim}, {RESP_OKAY, 10'h201})
    bus(1, 10'h0ec, 32'h0, q, r);
    `CHK(osc_trim, 10'h001)
    bus(1, 10'h0f4, 32'h2, q, r);
    `CHK(warning_threshold_select, 2'h2)
    bus(0, 10'h3fc, 0, q, r);
    `CHK({r, q}, {RESP_SLVERR, 32'h0})
    bus(1, 10'h0e8, 32'h0, q, r);
  endtask
  task automatic s_warn();
    bus(1, 10'h0f0, 32'h21, q, r);
    warn_cmd <= 1'b1;
    wait_mode <= 1'b1;
    cyc(6);
    `CHK({warn_irq, wake_req}, 2'b11)
    bus(0, 10'h0f0, 0, q, r);
    `CHK(q[ST_WARN_BIT], 1'b1)
    irq_ack <= 1'b1;
    cyc(1);
    irq_ack <= 1'b0;
    cyc(3);
    `CHK(warn_irq, 1'b0)
    warn_cmd <= 1'b0;
    cyc(6);
    `CHK(warn_irq, 1'b1)
    cpu_irq_mask <= 1'b1;
    cyc(2);
    `CHK(warn_irq, 1'b0)
    bus(1, 10'h0f0, 32'h23, q, r);
    bus(0, 10'h0f0, 0, q, r);
    `CHK(q[ST_WARN_BIT], 1'b0)
    halt_mode <= 1'b1;
    cpu_irq_mask <= 1'b0;
    warn_cmd <= 1'b1;
    cyc(6);
    bus(0, 10'h0f0, 0, q, r);
    `CHK({q[ST_WARN_BIT], wake_req}, 2'b00)
    halt_mode <= 1'b0;
    wait_mode <= 1'b0;
    warn_cmd <= 1'b0;
    irq_ack <= 1'b1;
    cyc(8);
    irq_ack <= 1'b0;
  endtask
  // Watchdog reset, then supply-low reset over it
  task automatic s_wdg();
    wdg_cmd <= 1'b1;
    cyc(3);
    wdg_cmd <= 1'b0;
    // Core still runs until the pulse has passed the synchroniser
    cyc(2);
    wait_run(n);
    `CHK(n >= WDG_PULSE_CYC, 1'b1)
    bus(0, 10'h0f0, 0, q, r);
    `CHK({q[ST_WDGRF_BIT], q[ST_LOWRF_BIT]}, 2'b10)
    for (int t = 0; t < 3; t++)
    begin
      opt_low_threshold <= 2'(t);
      cyc(2);
      `CHK(low_threshold_sel, 2'(t))
    end
    opt_low_detect_en <= 1'b0;
    low_cmd <= 1'b1;
    cyc(20);
    `CHK(cpu_run, 1'b1)
    opt_low_detect_en <= 1'b1;
    cyc(20);
    `CHK({reset_pin_oe, core_reset_n}, 2'b10)
    low_cmd <= 1'b0;
    wait_run(n);
    bus(0, 10'h0f0, 0, q, r);
    `CHK({q[ST_WDGRF_BIT], q[ST_LOWRF_BIT]}, 2'b01)
  endtask
  // External reset with the clock parked, then the delay length
  task automatic s_ext(input logic sh, input int dly);
    halt_mode <= 1'b1;
    opt_short_delay <= sh;
    cyc(1);
    clk_on = 1'b0;
    #300 ext_low = 1'b1;
    #200;
    `CHK(core_reset_n, 1'b0)
    clk_on = 1'b1;
    cyc(3);
    ext_low <= 1'b0;
    halt_mode <= 1'b0;
    wait_run(n);
    `CHK(n >= dly + 3 && n <= dly + 8, 1'b1)
  endtask
  initial
  begin
    {rstn, irq_ack, cpu_irq_mask, wait_mode, halt_mode, opt_short_delay} = '0;
    {ext_low, low_cmd, warn_cmd, wdg_cmd, s_awvalid, s_wvalid, s_arvalid} = '0;
    {s_bready, s_rready, s_awaddr, s_araddr, s_wdata, opt_low_threshold} = '0;
    opt_low_detect_en = 1'b1;
    s_wstrb = 4'h1;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    wait_run(n);
    s_regs();
    s_warn();
    s_wdg();
    s_ext(1'b0, DLY);
    s_ext(1'b1, DELAY_SHORT);
    results();
  end
endmodule
